// ### hdl/fbr_host_regs.vh
`ifndef FBR_HOST_REGS_VH
`define FBR_HOST_REGS_VH

// bus clock
`define FBR_CLK_PERIOD_NS      40

// reset pin timing
`define FBR_MIN_RESET_PULSE_NS 100
`define FBR_IDLE_RESET_NS      100
`define FBR_ERASE_ABORT_US     22
`define FBR_PROGRAM_ABORT_US   12
`define FBR_NS_PER_US          1000

// flip-flop stages on the returning data bus
`define FBR_SYNC_STAGES        2

// least time in ns to whole clock cycles, rounded up
`define FBR_CYC_UP(ns) (((ns) + `FBR_CLK_PERIOD_NS - 1) / `FBR_CLK_PERIOD_NS)

// kind of operation that a reset may interrupt
`define FBR_OP_NONE            2'h0
`define FBR_OP_PROGRAM         2'h1
`define FBR_OP_ERASE           2'h2

// pin levels
`define FBR_PIN_ASSERT         1'b0
`define FBR_PIN_RELEASE        1'b1

`endif

// ### hdl/fbr_timer.v
`timescale 1ns/1ps
`default_nettype none

module fbr_timer #(
   parameter CNT_W = 10
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             load,
   input  wire [CNT_W-1:0] load_val,
   output wire             done
);

   reg [CNT_W-1:0] count;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= {CNT_W{1'b0}};
      end else if (load) begin
         count <= load_val;
      end else if (count != {CNT_W{1'b0}}) begin
         count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   assign done = (count == {CNT_W{1'b0}}) && !load;

endmodule // fbr_timer

`default_nettype wire

// ### hdl/fbr_host.v
// What this block does
// - Read: select and output enable low, write strobe and reset high; device drives data.
// - Write: select and write strobe low, output enable and reset high; word to commands.
// - After reset release wait read recovery before reads, write recovery before writes.
// - After an abort, recovery delays count from the end of the shutdown interval.
// - System reset should also drive the device reset pin.
// - Hold the reset pin low at least 100 ns from read mode.
`timescale 1ns/1ps
`default_nettype none
`include "fbr_host_regs.vh"

module fbr_host #(
   parameter ADDR_W            = 21,
   parameter DATA_W            = 16,
   parameter CNT_W             = 10,
   parameter READ_ACCESS_NS    = 100,
   parameter WRITE_PULSE_NS    = 60,
   parameter READ_RECOVERY_NS  = 150,
   parameter WRITE_RECOVERY_NS = 150
) (
   input  wire              CLK,
   input  wire              RST_N,
   // user side
   input  wire              REQ_VALID,
   input  wire              REQ_WRITE,
   input  wire [ADDR_W-1:0] REQ_ADDR,
   input  wire [DATA_W-1:0] REQ_WDATA,
   output reg               RD_READY,
   output reg               WR_READY,
   output reg  [DATA_W-1:0] RD_DATA,
   output reg               RD_VALID,
   input  wire              RESET_REQ,
   input  wire [1:0]        OP_KIND,
   output reg               IN_RESET,
   // flash pins
   output reg               CE_N,
   output reg               OE_N,
   output reg               WE_N,
   output reg               RESET_POWERDOWN_N,
   output reg  [ADDR_W-1:0] ADDR,
   output reg  [DATA_W-1:0] DQ_O,
   output reg               DQ_OE,
   input  wire [DATA_W-1:0] DQ_I
);

   localparam integer PULSE_I  = `FBR_CYC_UP(`FBR_MIN_RESET_PULSE_NS);
   localparam integer IDLE_I   = `FBR_CYC_UP(`FBR_IDLE_RESET_NS);
   localparam integer ERASE_I  = `FBR_CYC_UP(`FBR_ERASE_ABORT_US * `FBR_NS_PER_US);
   localparam integer PROG_I   = `FBR_CYC_UP(`FBR_PROGRAM_ABORT_US * `FBR_NS_PER_US);
   localparam integer RD_REC_I = `FBR_CYC_UP(READ_RECOVERY_NS);
   localparam integer WR_REC_I = `FBR_CYC_UP(WRITE_RECOVERY_NS);
   // extra cycles cover the data synchroniser
   localparam integer RD_ACC_I = `FBR_CYC_UP(READ_ACCESS_NS) + `FBR_SYNC_STAGES;
   localparam integer WR_PUL_I = `FBR_CYC_UP(WRITE_PULSE_NS);
   // cut to the timer width on purpose: CNT_W must hold the longest hold
   localparam [CNT_W-1:0] PULSE_CYC  = PULSE_I[CNT_W-1:0];
   localparam [CNT_W-1:0] IDLE_CYC   = IDLE_I[CNT_W-1:0];
   localparam [CNT_W-1:0] ERASE_CYC  = ERASE_I[CNT_W-1:0];
   localparam [CNT_W-1:0] PROG_CYC   = PROG_I[CNT_W-1:0];
   localparam [CNT_W-1:0] RD_REC_CYC = RD_REC_I[CNT_W-1:0];
   localparam [CNT_W-1:0] WR_REC_CYC = WR_REC_I[CNT_W-1:0];
   localparam [CNT_W-1:0] RD_ACC_CYC = RD_ACC_I[CNT_W-1:0];
   localparam [CNT_W-1:0] WR_PUL_CYC = WR_PUL_I[CNT_W-1:0];
   localparam [CNT_W-1:0] REC_SAT    = {CNT_W{1'b1}};

   localparam [7:0] S_START = 8'h01;
   localparam [7:0] S_HOLD  = 8'h02;
   localparam [7:0] S_IDLE  = 8'h04;
   localparam [7:0] S_READ  = 8'h08;
   localparam [7:0] S_WRITE = 8'h10;
   localparam [7:0] S_WHOLD = 8'h20;
   localparam [7:0] S_GAP   = 8'h40;

   reg  [7:0]        state;
   reg  [1:0]        abort_kind;
   reg  [CNT_W-1:0]  rec_cnt;
   reg  [DATA_W-1:0] dq_meta;
   reg  [DATA_W-1:0] dq_sync;
   reg               tmr_load;
   reg  [CNT_W-1:0]  tmr_val;
   reg  [CNT_W-1:0]  hold_cyc;
   wire              tmr_done;
   wire              rd_ok;
   wire              wr_ok;
   wire              take;

   fbr_timer #(
      .CNT_W    (CNT_W)
   ) u_timer (
      .clk      (CLK),
      .rst_n    (RST_N),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   // data pins change outside our clock
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         dq_meta <= {DATA_W{1'b0}};
         dq_sync <= {DATA_W{1'b0}};
      end else begin
         dq_meta <= DQ_I;
         dq_sync <= dq_meta;
      end
   end

   // an aborted operation needs its shutdown before release
   always @* begin
      case (abort_kind)
         `FBR_OP_ERASE:   hold_cyc = ERASE_CYC;
         `FBR_OP_PROGRAM: hold_cyc = PROG_CYC;
         default:         hold_cyc = (PULSE_CYC > IDLE_CYC) ? PULSE_CYC : IDLE_CYC;
      endcase
   end

   assign rd_ok = (rec_cnt >= RD_REC_CYC);
   assign wr_ok = (rec_cnt >= WR_REC_CYC);
   assign take  = (state == S_IDLE) && REQ_VALID && !RESET_REQ &&
                  (REQ_WRITE ? WR_READY : RD_READY);

   always @* begin
      tmr_load = 1'b0;
      tmr_val  = {CNT_W{1'b0}};
      case (state)
         S_START: begin
            tmr_load = 1'b1;
            tmr_val  = (hold_cyc > PULSE_CYC) ? hold_cyc : PULSE_CYC;
         end
         S_IDLE: begin
            if (take) begin
               tmr_load = 1'b1;
               tmr_val  = REQ_WRITE ? WR_PUL_CYC : RD_ACC_CYC;
            end
         end
         default: begin
            tmr_load = 1'b0;
         end
      endcase
   end

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         // system reset drives the flash reset pin as well
         state             <= S_START;
         abort_kind        <= `FBR_OP_ERASE;
         RESET_POWERDOWN_N <= `FBR_PIN_ASSERT;
         rec_cnt           <= {CNT_W{1'b0}};
         CE_N              <= `FBR_PIN_RELEASE;
         OE_N              <= `FBR_PIN_RELEASE;
         WE_N              <= `FBR_PIN_RELEASE;
         ADDR              <= {ADDR_W{1'b0}};
         DQ_O              <= {DATA_W{1'b0}};
         DQ_OE             <= 1'b0;
         RD_DATA           <= {DATA_W{1'b0}};
         RD_VALID          <= 1'b0;
         RD_READY          <= 1'b0;
         WR_READY          <= 1'b0;
         IN_RESET          <= 1'b1;
      end else begin
         RD_VALID <= 1'b0;
         RD_READY <= 1'b0;
         WR_READY <= 1'b0;
         if (rec_cnt != REC_SAT) begin
            rec_cnt <= rec_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         case (state)
            S_START: begin
               state <= S_HOLD;
            end
            S_HOLD: begin
               // other pins are don't care to the device, keep them idle
               if (tmr_done) begin
                  RESET_POWERDOWN_N <= `FBR_PIN_RELEASE;
                  rec_cnt           <= {CNT_W{1'b0}};
                  IN_RESET          <= 1'b0;
                  state             <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (RESET_REQ) begin
                  // floats nothing to do: data bus is already released in idle
                  abort_kind        <= OP_KIND;
                  RESET_POWERDOWN_N <= `FBR_PIN_ASSERT;
                  IN_RESET          <= 1'b1;
                  state             <= S_START;
               end else if (take) begin
                  ADDR <= REQ_ADDR;
                  CE_N <= `FBR_PIN_ASSERT;
                  if (REQ_WRITE) begin
                     WE_N  <= `FBR_PIN_ASSERT;
                     DQ_O  <= REQ_WDATA;
                     DQ_OE <= 1'b1;
                     state <= S_WRITE;
                  end else begin
                     OE_N  <= `FBR_PIN_ASSERT;
                     state <= S_READ;
                  end
               end else begin
                  RD_READY <= rd_ok;
                  WR_READY <= wr_ok;
               end
            end
            S_READ: begin
               if (tmr_done) begin
                  // status words come back here too while an operation runs
                  RD_DATA  <= dq_sync;
                  RD_VALID <= 1'b1;
                  OE_N     <= `FBR_PIN_RELEASE;
                  CE_N     <= `FBR_PIN_RELEASE;
                  state    <= S_GAP;
               end
            end
            S_WRITE: begin
               if (tmr_done) begin
                  // strobe rises first so it alone marks the latch point
                  WE_N  <= `FBR_PIN_RELEASE;
                  state <= S_WHOLD;
               end
            end
            S_WHOLD: begin
               // data held one cycle past the strobe edge
               CE_N  <= `FBR_PIN_RELEASE;
               DQ_OE <= 1'b0;
               state <= S_GAP;
            end
            S_GAP: begin
               // turnaround cycle so the device stops driving before we may
               state <= S_IDLE;
            end
            default: begin
               state <= S_START;
            end
         endcase
      end
   end

endmodule // fbr_host

`default_nettype wire

// ### sim/fbr_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbr_flash_model #(
   parameter ACC_NS  = 70,
   parameter BUSY_NS = 2000
) (
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        reset_powerdown_n,
   input  wire logic [20:0] addr,
   input  wire logic [15:0] din,
   output wire logic [15:0] dout
);
   logic [15:0] mem [0:15];
   logic [15:0] val;
   logic [15:0] pd;
   logic [3:0]  pa;
   logic        busy;
   logic        setup;
   logic        stat_mode;
   logic        drive;
   initial begin
      for (int i = 0; i < 16; i++)
         mem[i] = 16'h1000 + 16'(i);
      {busy, setup, stat_mode} = 3'h0;
   end
   assign val = (stat_mode || busy) ? {8'h00, ~busy, 7'h00} : mem[addr[3:0]];
   assign drive = !ce_n && !oe_n && we_n && reset_powerdown_n;
   // released bus shows the inverse so a stale value never passes
   assign #(ACC_NS) dout = drive ? val : ~val;
   // only the first rising edge sees the other control still low
   always @(posedge we_n or posedge ce_n) begin
      if (reset_powerdown_n === 1'b1 && oe_n && (ce_n ^ we_n)) begin
         if (setup) begin
            {pa, pd} = {addr[3:0], din};
            {busy, setup, stat_mode} = 3'h5;
         end else if (!busy) begin
            case (din[7:0])
               8'h40: setup = 1'b1;
               8'h70: stat_mode = 1'b1;
               8'hff: stat_mode = 1'b0;
               default: ;
            endcase
         end
      end
   end
   always @(posedge busy) begin
      #(BUSY_NS);
      if (busy)
         mem[pa] = pd;
      busy = 1'b0;
   end
   always @(negedge reset_powerdown_n) begin
      if (busy)
         mem[pa] = ~pd;
      {busy, setup, stat_mode} = 3'h0;
   end
endmodule // fbr_flash_model
`default_nettype wire

// ### sim/fbr_host_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fbr_host_checker #(
   parameter ADDR_W = 21,
   parameter DATA_W = 16
) (
   input wire logic              CLK,
   input wire logic              RST_N,
   input wire logic              RD_READY,
   input wire logic              WR_READY,
   input wire logic              RD_VALID,
   input wire logic              IN_RESET,
   input wire logic              CE_N,
   input wire logic              OE_N,
   input wire logic              WE_N,
   input wire logic              RESET_POWERDOWN_N,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] DQ_O,
   input wire logic              DQ_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   rd_pins_a: assert property (!OE_N |-> !CE_N && WE_N && RESET_POWERDOWN_N && !DQ_OE)
      else $error("read pin pattern wrong");
   wr_pins_a: assert property (!WE_N |-> !CE_N && OE_N && RESET_POWERDOWN_N && DQ_OE)
      else $error("write pin pattern wrong");
   rd_timing_a: assert property ($fell(OE_N) |-> !OE_N[*6] ##1 (RD_VALID && OE_N))
      else $error("read access length wrong");
   wr_latch_a: assert property ($fell(WE_N) |-> !WE_N[*3] ##1 (WE_N && !CE_N) ##1 CE_N)
      else $error("strobe does not end the write");
   wr_hold_a: assert property ($rose(WE_N) |-> DQ_OE && $stable(ADDR) && $stable(DQ_O))
      else $error("write data moved at latch edge");
   rst_pulse_a: assert property ($fell(RESET_POWERDOWN_N) |-> !RESET_POWERDOWN_N[*3])
      else $error("reset pulse too short");
   rst_quiet_a: assert property (!RESET_POWERDOWN_N |-> IN_RESET && CE_N && OE_N && WE_N)
      else $error("bus active during reset");
   rd_recov_a: assert property ($rose(RESET_POWERDOWN_N) |-> !RD_READY[*4])
      else $error("read recovery too short");
   wr_recov_a: assert property ($rose(RESET_POWERDOWN_N) |-> !WR_READY[*4])
      else $error("write recovery too short");
endmodule // fbr_host_checker
bind fbr_host fbr_host_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) fbr_host_checker_inst (
   .CLK(CLK), .RST_N(RST_N), .RD_READY(RD_READY), .WR_READY(WR_READY), .RD_VALID(RD_VALID),
   .IN_RESET(IN_RESET), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N),
   .RESET_POWERDOWN_N(RESET_POWERDOWN_N), .ADDR(ADDR), .DQ_O(DQ_O), .DQ_OE(DQ_OE));
`default_nettype wire

// ### sim/tb_fbr_host.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fbr_host;
   logic        clk, rst_n, req_valid, req_write, reset_req;
   logic        rd_ready, wr_ready, rd_valid, in_reset, ce_n, oe_n, we_n, rp_n, dq_oe;
   logic [1:0]  op_kind;
   logic [20:0] req_addr, addr;
   logic [15:0] req_wdata, rd_data, dq_o, dq_m, dq_w, rd;
   int          fails, checks, cnt;
   assign dq_w = dq_oe ? dq_o : dq_m;
   fbr_host fbr_host_inst (.CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
      .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RD_READY(rd_ready), .WR_READY(wr_ready),
      .RD_DATA(rd_data), .RD_VALID(rd_valid), .RESET_REQ(reset_req), .OP_KIND(op_kind),
      .IN_RESET(in_reset), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .RESET_POWERDOWN_N(rp_n),
      .ADDR(addr), .DQ_O(dq_o), .DQ_OE(dq_oe), .DQ_I(dq_w));
   fbr_flash_model fbr_flash_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .reset_powerdown_n(rp_n), .addr(addr), .din(dq_w), .dout(dq_m));
   always #20 clk = ~clk;
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wait_ready(input logic wr);
      int n;
      n = 0;
      while ((wr ? wr_ready : rd_ready) !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000)
         fails++;
   endtask
   task automatic bus_write(input logic [20:0] a, input logic [15:0] d);
      wait_ready(1'b1);
      {req_valid, req_write, req_addr, req_wdata} = {2'h3, a, d};
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   task automatic bus_read(input logic [20:0] a, output logic [15:0] d);
      int n;
      wait_ready(1'b0);
      {req_valid, req_write, req_addr} = {2'h2, a};
      n = 0;
      @(negedge clk);
      req_valid = 1'b0;
      while (rd_valid !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      if (n >= 50)
         fails++;
      d = rd_data;
   endtask
   task automatic count_low(output int c);
      c = 0;
      while (rp_n !== 1'b1 && c < 5000) begin
         @(negedge clk);
         c++;
      end
      if (c >= 5000)
         fails++;
   endtask
   task automatic t_commands;
      count_low(cnt);
      check("power-on hold", 16'(cnt >= 550), 16'h1);
      bus_read(21'h3, rd);
      check("array after reset", rd, 16'h1003);
      bus_write(21'h5, 16'h00ff);
      bus_read(21'h5, rd);
      check("array under command", rd, 16'h1005);
      bus_write(21'h1a5, 16'h0070);
      bus_read(21'h0, rd);
      check("status idle", rd, 16'h0080);
      bus_write(21'h2, 16'h0040);
      bus_write(21'h2, 16'hbeef);
      bus_read(21'h2, rd);
      check("status busy", rd, 16'h0000);
      for (int i = 0; i < 40 && rd !== 16'h0080; i++)
         bus_read(21'h2, rd);
      bus_write(21'h2, 16'h00ff);
      bus_read(21'h2, rd);
      check("programmed word", rd, 16'hbeef);
      $display("test commands done");
   endtask
   task automatic t_resets;
      int lim [4] = '{3, 300, 550, 3};
      for (int k = 0; k < 4; k++) begin
         if (k == 1) begin
            bus_write(21'h7, 16'h0040);
            bus_write(21'h7, 16'h1234);
         end
         wait_ready(1'b0);
         {reset_req, op_kind} = {1'b1, 2'(k)};
         @(negedge clk);
         reset_req = 1'b0;
         @(negedge clk);
         check("pin low on request", {15'h0, rp_n}, 16'h0);
         check("reset flag on request", {15'h0, in_reset}, 16'h1);
         count_low(cnt);
         check("reset hold", 16'(cnt >= lim[k]), 16'h1);
         bus_read(21'h1, rd);
         check("read after reset", rd, 16'h1001);
      end
      $display("test resets done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {clk, rst_n, req_valid, req_write, reset_req} = 5'h0;
      req_addr = 21'h0;
      req_wdata = 16'h0;
      op_kind = 2'h0;
      fails = 0;
      checks = 0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      t_commands();
      t_resets();
      tally_and_finish();
   end
   initial begin
      #(40 * 20000);
      fails++;
      tally_and_finish();
   end
endmodule // tb_fbr_host
`default_nettype wire
